//--- serial_port_cfg.svh
// Constants for the serial slave port: word size and pin polarities.
// Assumes inclusion by bare name from the package and design files.
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH
`define WORD_BITS 8
`define CNT_W 3
`define CNT_LAST 3'h7
`define CNT_ZERO 3'h0
`define BYTE_ZERO 8'h00
`define STAT_ZERO 8'h00
`define EVT_W 4
`define EVT_ZERO 4'h0
`define SEL_IDLE 1'b1
`endif

//--- serial_port_pkg.sv
// Types shared by the serial slave port files.
// Assumes the constants header is on the include path.
`include "serial_port_cfg.svh"
package serial_port_pkg;
   typedef logic [`WORD_BITS-1:0] byte_t;
   typedef logic [`EVT_W-1:0] event_vec_t;
endpackage : serial_port_pkg

//--- pin_sync.sv
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input is a pin level with no relation to ref_clk_i.
`timescale 1ns/10ps
module pin_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic async_i,
   output logic sync_o
);
   typedef struct packed {
      logic meta;
      logic stable;
   } sync_state_t;
   sync_state_t st, next_st;
   always_comb begin
      next_st = st;
      next_st.meta = async_i;
      next_st.stable = st.meta;
   end
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= {RST_VAL, RST_VAL};
      end else begin
         st <= next_st;
      end
   end
   assign sync_o = st.stable;
endmodule : pin_sync

//--- serial_port_slave.sv
// Serial slave port pins: select gating, input capture, output launch, passthrough, interrupt pin.
// Assumes the serial clock is much slower than ref_clk_i and is sampled as a plain input.
// Notes on behaviour
// R1: Input data is sampled on each rising serial clock edge while selected.
// R2: The first output bit is launched when select falls; each later bit on the falling serial clock edge.
// R3: While select is high the data output is not driven.
// R4: Clock edges are ignored unless select is low; the master keeps select low for the whole transfer.
// R5: In passthrough mode the data output follows the first user I/O pin.
// R6: The interrupt pin has a programmable active level and flags converter, wake-up, alarm and supply events.
// R7: A transfer runs from select falling to select rising and a partial word is dropped at deselect.
`timescale 1ns/10ps
`include "serial_port_cfg.svh"
module serial_port_slave (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic sclk_i,
   input wire logic sel_n_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_n_o,
   input wire logic user_io_pin_one_i,
   input wire logic passthrough_en_i,
   input wire logic irq_active_high_i,
   input wire serial_port_pkg::event_vec_t event_i,
   input wire serial_port_pkg::byte_t tx_word_i,
   output serial_port_pkg::byte_t rx_word_o,
   output logic rx_valid_o,
   output logic tx_load_o,
   output logic irq_o
);
   import serial_port_pkg::*;

   logic sclk_s, sel_n_s, sdi_s, upio_s;

   pin_sync u_sync_sclk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .async_i(sclk_i), .sync_o(sclk_s));
   // Select resets to its idle level, so no phantom transfer opens right after reset.
   pin_sync #(.RST_VAL(`SEL_IDLE)) u_sync_sel (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .async_i(sel_n_i),
      .sync_o(sel_n_s));
   pin_sync u_sync_sdi (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .async_i(sdi_i), .sync_o(sdi_s));
   pin_sync u_sync_upio (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .async_i(user_io_pin_one_i),
      .sync_o(upio_s));

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XFER = 2'b01
   } port_state_t;

   typedef struct packed {
      port_state_t fsm;
      logic sclk_d;
      logic [`CNT_W-1:0] bit_cnt;
      byte_t rx_sh;
      byte_t tx_sh;
      byte_t rx_word;
      logic rx_valid;
      logic tx_load;
      logic sdo;
      logic oe_n;
      logic irq;
   } port_t;

   port_t st, next_st;
   logic rise, fall;

   always_comb begin
      rise = sclk_s & ~st.sclk_d;
      fall = ~sclk_s & st.sclk_d;
      next_st = st;
      next_st.sclk_d = sclk_s;
      next_st.rx_valid = 1'b0;
      next_st.tx_load = 1'b0;
      next_st.irq = irq_active_high_i ? (|event_i) : ~(|event_i); // R6
      case (st.fsm)
         ST_IDLE: begin
            next_st.bit_cnt = `CNT_ZERO; // R7
            next_st.rx_sh = `BYTE_ZERO;
            if (!sel_n_s) begin
               next_st.fsm = ST_XFER; // R7
               next_st.tx_sh = tx_word_i;
               next_st.tx_load = 1'b1;
               next_st.sdo = tx_word_i[`WORD_BITS-1];
            end
         end
         ST_XFER: begin
            if (sel_n_s) begin
               next_st.fsm = ST_IDLE; // R7
            end else begin
               if (rise) begin // R1 R4
                  next_st.rx_sh = {st.rx_sh[`WORD_BITS-2:0], sdi_s};
                  next_st.bit_cnt = st.bit_cnt + 1'b1;
                  if (st.bit_cnt == `CNT_LAST) begin
                     next_st.rx_word = {st.rx_sh[`WORD_BITS-2:0], sdi_s};
                     next_st.rx_valid = 1'b1;
                  end
               end
               if (fall) begin // R2
                  if (st.bit_cnt == `CNT_ZERO) begin
                     next_st.tx_sh = tx_word_i;
                     next_st.tx_load = 1'b1;
                     next_st.sdo = tx_word_i[`WORD_BITS-1];
                  end else begin
                     next_st.tx_sh = {st.tx_sh[`WORD_BITS-2:0], 1'b0};
                     next_st.sdo = st.tx_sh[`WORD_BITS-2];
                  end
               end
            end
         end
         default: next_st.fsm = ST_IDLE;
      endcase
      if (passthrough_en_i) begin
         next_st.sdo = upio_s; // R5
      end
      next_st.oe_n = sel_n_s; // R3
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= '0;
         st.fsm <= ST_IDLE;
         st.oe_n <= 1'b1;
         st.irq <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign sdo_o = st.sdo;
   assign sdo_oe_n_o = st.oe_n;
   assign rx_word_o = st.rx_word;
   assign rx_valid_o = st.rx_valid;
   assign tx_load_o = st.tx_load;
   assign irq_o = st.irq;

   deselect_hiz_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R3
      sel_n_s |=> sdo_oe_n_o) else $error("data output driven while deselected");
   select_drive_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R3
      !sel_n_s |=> !sdo_oe_n_o) else $error("data output not driven while selected");
   capture_gate_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R4
      rx_valid_o |-> $past(!sel_n_s && rise)) else $error("word taken without selected rising edge");
   word_value_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R1
      rx_valid_o |-> rx_word_o[0] == $past(sdi_s)) else $error("last bit not sampled at rising edge");
   launch_edge_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R2
      (!passthrough_en_i && st.fsm == ST_XFER && !sel_n_s && !fall && !rise) |=> $stable(sdo_o))
      else $error("output changed away from falling edge");
   passthru_follow_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R5
      passthrough_en_i |=> sdo_o == $past(upio_s)) else $error("passthrough not following pin");
   irq_level_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R6
      1'b1 |=> irq_o == ($past(irq_active_high_i) ~^ $past(|event_i)))
      else $error("interrupt level wrong");
   drop_partial_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R7
      (st.fsm == ST_XFER && sel_n_s) |=> ##1 st.bit_cnt == `CNT_ZERO)
      else $error("partial word kept after deselect");

   // Framing: select opens and closes a transfer and reloads the transmit word.

   start_xfer_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R7
      (st.fsm == ST_IDLE && !sel_n_s)
      |=> st.fsm == ST_XFER)
      else $error("transfer not opened at select");

   load_at_select_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R7
      (st.fsm == ST_IDLE && !sel_n_s)
      |=> tx_load_o)
      else $error("transmit word not taken at select");

   first_bit_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R2
      (st.fsm == ST_IDLE && !sel_n_s && !passthrough_en_i)
      |=> sdo_o == $past(tx_word_i[`WORD_BITS-1]))
      else $error("first bit not presented at select");

   end_xfer_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R7
      (st.fsm == ST_XFER && sel_n_s)
      |=> st.fsm == ST_IDLE)
      else $error("transfer not closed at deselect");

   // Gating: nothing is taken in while select is high or without a rising edge, and the idle output holds.

   idle_no_word_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R4
      (st.fsm == ST_IDLE || sel_n_s)
      |=> !rx_valid_o)
      else $error("word reported while deselected");

   deselect_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R4
      sel_n_s
      |=> $stable(rx_word_o))
      else $error("received word changed while deselected");

   quiet_count_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R4
      (st.fsm == ST_XFER && !rise)
      |=> $stable(st.bit_cnt))
      else $error("bit count moved without a rising edge");

   idle_sdo_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R3
      (st.fsm == ST_IDLE && sel_n_s && !passthrough_en_i)
      |=> $stable(sdo_o))
      else $error("data output moved while deselected");

   // Shifting: one bit in per rising edge, one bit out per falling edge.

   rise_shift_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R1
      (st.fsm == ST_XFER && !sel_n_s && rise)
      |=> st.rx_sh[0] == $past(sdi_s))
      else $error("input bit not shifted in at rising edge");

   rise_count_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R1
      (st.fsm == ST_XFER && !sel_n_s && rise)
      |=> st.bit_cnt == $past(st.bit_cnt) + 1'b1)
      else $error("bit count not advanced at rising edge");

   word_done_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R1
      (st.fsm == ST_XFER && !sel_n_s && rise && st.bit_cnt == `CNT_LAST)
      |=> rx_valid_o)
      else $error("full word not reported");

   valid_pulse_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R1
      rx_valid_o
      |=> !rx_valid_o)
      else $error("word strobe longer than one cycle");

   fall_next_bit_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R2
      (!passthrough_en_i && st.fsm == ST_XFER && !sel_n_s && fall && st.bit_cnt != `CNT_ZERO)
      |=> sdo_o == $past(st.tx_sh[`WORD_BITS-2]))
      else $error("next bit not launched at falling edge");

   refill_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // R2
      (st.fsm == ST_XFER && !sel_n_s && fall && st.bit_cnt == `CNT_ZERO)
      |=> tx_load_o)
      else $error("transmit word not reloaded after a full word");
endmodule : serial_port_slave

//--- spi_host.sv
// Host master model: drives select, serial clock and data in.
// Assumes the bench resolves the data output wire.
`timescale 1ns/10ps
module spi_host (
   input wire logic sdo_i,
   output logic sclk_o,
   output logic sel_n_o,
   output logic sdi_o
);
   initial begin
      sclk_o = 1'b0;
      sel_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      sel_n_o <= 1'b0;
      #200;
      for (int i = 0; i < nb; i++) begin
         sdi_o <= tx[7-i];
         #100 sclk_o <= 1'b1;
         rx = {rx[6:0], sdo_i};
         #100 sclk_o <= 1'b0;
      end
      #200 sel_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
      #200;
   endtask : xfer
   task automatic idle(input int n);
      repeat (n) begin
         #100 sclk_o <= 1'b1;
         #100 sclk_o <= 1'b0;
      end
   endtask : idle
endmodule : spi_host

//--- serial_port_pin_behaviour_bench.sv
// Self-checking bench for the serial slave port.
// Assumes the host model drives the serial pins.
`timescale 1ns/10ps
module serial_port_pin_behaviour_bench;
   import serial_port_pkg::*;
   logic ref_clk_i = 0, sys_rst_i = 1, pt_en = 0, pin1 = 0, pol = 1;
   logic sclk, sel_n, sdi, sdo, oe_n, rx_valid, irq, tx_load;
   event_vec_t ev = 4'h0;
   byte_t tx = 8'h00, rx_word, r;
   wire sdo_line = oe_n ? 1'bz : sdo;
   int n_mismatch = 0, check_count = 0, n_valid = 0, n_load = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) if (rx_valid === 1'b1) n_valid++;
   always @(posedge ref_clk_i) if (tx_load === 1'b1) n_load++;
   serial_port_slave dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .sel_n_i(sel_n),
      .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(oe_n), .user_io_pin_one_i(pin1), .passthrough_en_i(pt_en),
      .irq_active_high_i(pol), .event_i(ev), .tx_word_i(tx), .rx_word_o(rx_word), .rx_valid_o(rx_valid),
      .tx_load_o(tx_load), .irq_o(irq));
   spi_host host (.sdo_i(sdo_line), .sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(sdi));
   task automatic chk1(input logic g, input logic e, input string m);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask : chk1
   task automatic chk8(input byte_t g, input byte_t e, input string m);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask : chk8
   task automatic t_word;
      int v;
      int w;
      v = n_valid;
      w = n_load;
      @(posedge ref_clk_i) tx <= 8'hA5;
      host.xfer(8'h3C, 8, r);
      chk8(r, 8'hA5, "sdo word");
      chk1(n_load == w + 2, 1'b1, "load count");
      chk8(rx_word, 8'h3C, "sdi word");
      chk1(n_valid == v + 1, 1'b1, "valid count");
      chk1(oe_n, 1'b1, "oe after deselect");
   endtask : t_word
   task automatic t_drop;
      int v;
      int w;
      v = n_valid;
      w = n_load;
      host.idle(9);
      host.xfer(8'hFF, 5, r);
      chk1(n_valid == v, 1'b1, "spurious valid");
      chk1(n_load == w + 1, 1'b1, "partial load count");
      chk8(r, 8'h14, "partial sdo");
      host.xfer(8'hC3, 8, r);
      chk8(rx_word, 8'hC3, "word after drop");
      chk8(r, 8'hA5, "sdo after drop");
   endtask : t_drop
   task automatic t_pass;
      @(posedge ref_clk_i) pt_en <= 1'b1;
      pin1 <= 1'b1;
      host.xfer(8'h00, 8, r);
      chk8(r, 8'hFF, "pass high");
      @(posedge ref_clk_i) pin1 <= 1'b0;
      host.xfer(8'h00, 8, r);
      chk8(r, 8'h00, "pass low");
      chk1(oe_n, 1'b1, "pass oe after deselect");
      @(posedge ref_clk_i) pt_en <= 1'b0;
   endtask : t_pass
   task automatic t_irq;
      for (int k = 0; k < 32; k++) begin
         @(posedge ref_clk_i) pol <= k[4];
         ev <= k[3:0];
         repeat (3) @(posedge ref_clk_i);
         #1 chk1(irq, k[4] ? |k[3:0] : ~|k[3:0], "irq level");
      end
   endtask : t_irq
   task automatic summarize;
      if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      repeat (6) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      chk1(oe_n, 1'b1, "idle oe");
      t_word();
      t_drop();
      t_pass();
      t_irq();
      summarize();
   end
   initial begin
      #100000;
      n_mismatch++;
      summarize();
   end
endmodule : serial_port_pin_behaviour_bench
